// ===== rtl/acc_params.svh
// Constants for the conversion, clock and reset control block.
`ifndef ACC_PARAMS_SVH
`define ACC_PARAMS_SVH

// ****************************************************************
// Register offsets (byte addresses on the bus).
// ****************************************************************
`define ACC_MODE_CFG_OFS    8'h00
`define ACC_PERIOD_OFS      8'h04
`define ACC_LATENCY_OFS     8'h08
`define ACC_STATUS_OFS      8'h0c

// ****************************************************************
// Field positions and reset values.
// ****************************************************************
`define ACC_CONV_MODE_BIT   4
`define ACC_DELAY_LSB       0
`define ACC_DELAY_MSB       3
`define ACC_MODE_CFG_RST    32'h0000_0001
`define ACC_PERIOD_RST      24'h004e20
`define ACC_LATENCY_RST     4'h0
`define ACC_ST_RESET_BIT    0
`define ACC_ST_CLOCK_BIT    1
`define ACC_ST_BUSY_BIT     2
`define ACC_ST_COMM_BIT     3

// ****************************************************************
// Timing figures and counts.
// ****************************************************************
`define ACC_CLK_PERIOD_NS   20
`define ACC_DLY_UNIT_NS     50000
`define ACC_POR_CYCLES      65536
`define ACC_BOOT_CYCLES     512
`define ACC_EXT_TIMEOUT     6'h20

`endif

// ===== rtl/acc_pkg.sv
// Types shared by the conversion, clock and reset control block.
package acc_pkg;

   // Control sequencer states.
   typedef enum logic [2:0] {
      ST_POR,
      ST_BOOT,
      ST_IDLE,
      ST_DELAY,
      ST_CONV
   } acc_state_t;

   // Decoded serial commands, each a one-cycle pulse.
   typedef struct packed {
      logic start;
      logic stop;
      logic reset;
   } acc_cmd_t;

   // Pins arriving from outside the clock domain.
   typedef struct packed {
      logic extClk;
      logic resetN;
      logic start;
   } acc_pins_t;

endpackage : acc_pkg

// ===== rtl/acc_pin_sync.sv
// Two-stage synchroniser for a group of asynchronous inputs.
`timescale 1ns/1ns
module acc_pin_sync #(
   parameter int WIDTH = 3
) (
   input  wire logic             clk,
   input  wire logic             resetn,
   input  wire logic             clkEn,
   input  wire logic [WIDTH-1:0] rstVal,
   input  wire logic [WIDTH-1:0] asyncIn,
   output logic      [WIDTH-1:0] syncOut
);

   // ****************************************************************
   // One synchroniser per bit.
   // ****************************************************************
   genvar gi;
   generate
      for (gi = 0; gi < WIDTH; gi++) begin : g_bit
         logic meta_ff; // First stage, read only by the second.
         logic sync_ff; // Second stage, safe for logic.

         // Both stages load a fixed idle value at reset.
         always_ff @(posedge clk) begin
            if (!resetn) begin
               meta_ff <= 1'b0;
               sync_ff <= 1'b0;
            end else if (clkEn) begin
               meta_ff <= asyncIn[gi] ^ rstVal[gi];
               sync_ff <= meta_ff;
            end
         end
         assign syncOut[gi] = sync_ff ^ rstVal[gi];
      end
   endgenerate

endmodule : acc_pin_sync

// ===== rtl/acc_conv_ctl.sv
// Conversion control, clock detection and reset sequencing with AHB regs.
`timescale 1ns/1ns
`include "acc_params.svh"
module acc_conv_ctl #(
   parameter int POR_CYCLES = `ACC_POR_CYCLES
) (
   input  wire logic              clk,
   input  wire logic              resetn,
   input  wire logic              clkEn,
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic      [31:0]       hrdata,
   output logic                   hreadyout,
   output logic                   hresp,
   input  wire acc_pkg::acc_pins_t pinsIn,
   input  wire acc_pkg::acc_cmd_t  cmdIn,
   output logic                   resultReadyN,
   output logic                   filterRun,
   output logic                   extClkSel
);

   // ****************************************************************
   // Derived timing counts.
   // ****************************************************************
   // Cycles of one start-delay unit, rounded up.
   localparam int DLY_UNIT =
      (`ACC_DLY_UNIT_NS + `ACC_CLK_PERIOD_NS - 1) / `ACC_CLK_PERIOD_NS;
   localparam logic [23:0] DLY_UNIT_C = 24'(DLY_UNIT);
   localparam logic [23:0] POR_C      = 24'(POR_CYCLES - 1);
   localparam logic [23:0] BOOT_C     = 24'(`ACC_BOOT_CYCLES - 1);

   // ****************************************************************
   // Pin synchronisers and clock detection.
   // ****************************************************************
   acc_pkg::acc_pins_t pinsSync;       // Synchronised pin levels.
   logic               startPrev_ff;   // Start level one cycle back.
   logic               extPrev_ff;     // Clock level one cycle back.
   logic [5:0]         extIdle_ff;     // Cycles since last clock edge.
   logic               startRise;      // Start pin rising edge.
   logic               startFall;      // Start pin falling edge.

   // The reset pin idles high, so its synchronised level reads one at reset.
   acc_pin_sync #(
      .WIDTH  (3)
   ) u_sync (
      .clk     (clk),
      .resetn  (resetn),
      .clkEn   (clkEn),
      .rstVal  (3'b010),
      .asyncIn (pinsIn),
      .syncOut (pinsSync)
   );

   assign startRise = pinsSync.start & ~startPrev_ff;
   assign startFall = ~pinsSync.start & startPrev_ff;

   // Edge history for the start pin and the external clock.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         startPrev_ff <= 1'b0;
         extPrev_ff   <= 1'b0;
      end else if (clkEn) begin
         startPrev_ff <= pinsSync.start;
         extPrev_ff   <= pinsSync.extClk;
      end
   end

   // Any edge on the clock input counts as presence; a quiet or grounded
   // input times out and falls back to the internal oscillator.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         extIdle_ff <= `ACC_EXT_TIMEOUT;
         extClkSel  <= 1'b0;
      end else if (clkEn) begin
         if (pinsSync.extClk != extPrev_ff) begin
            extIdle_ff <= 6'h00;
            extClkSel  <= 1'b1;
         end else if (extIdle_ff != `ACC_EXT_TIMEOUT) begin
            extIdle_ff <= extIdle_ff + 6'h01;
         end else begin
            extClkSel  <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // Reset sources.
   // ****************************************************************
   logic softRst;    // Reset pin held low or reset command.
   logic regRst;     // Any of the three resets.

   // The command already arrives on its 32nd serial clock edge.
   assign softRst = ~pinsSync.resetN | cmdIn.reset;
   assign regRst  = ~resetn | softRst;

   // ****************************************************************
   // Registers.
   // ****************************************************************
   logic [31:0] modeCfg_ff;    // Mode configuration register.
   logic [23:0] period_ff;     // Conversion period in cycles.
   logic [3:0]  latency_ff;    // Extra settling periods of the first.
   logic        rstFlag_ff;    // Sticky reset-occurred flag.
   logic        commRdy_ff;    // Serial link may be used.
   logic        wrPend_ff;     // Write data phase pending.
   logic [7:0]  wrAddr_ff;     // Address captured for the write.
   logic        busAct;        // Valid address phase to this slave.
   logic        flagClr;       // Software clear of the reset flag.
   logic        convMode;      // High selects pulse mode.
   logic [3:0]  delayField;    // Start delay in units.
   acc_pkg::acc_state_t state_ff;   // Sequencer state.
   acc_pkg::acc_state_t nxt_state;  // Next sequencer state.

   assign busAct     = hsel & hready & htrans[1];
   assign convMode   = modeCfg_ff[`ACC_CONV_MODE_BIT];
   assign delayField = modeCfg_ff[`ACC_DELAY_MSB:`ACC_DELAY_LSB];
   assign flagClr    = wrPend_ff && (wrAddr_ff == `ACC_STATUS_OFS)
                       && hwdata[`ACC_ST_RESET_BIT];

   // Address phase capture; only whole-word writes are stored.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         wrPend_ff <= 1'b0;
         wrAddr_ff <= 8'h00;
      end else if (clkEn) begin
         wrPend_ff <= busAct & hwrite & (hsize == 3'h2);
         wrAddr_ff <= haddr[7:0];
      end
   end

   // Writable registers; every reset source restores defaults.
   always_ff @(posedge clk) begin
      if (regRst) begin
         modeCfg_ff <= `ACC_MODE_CFG_RST;
         period_ff  <= `ACC_PERIOD_RST;
         latency_ff <= `ACC_LATENCY_RST;
      end else if (clkEn && wrPend_ff) begin
         case (wrAddr_ff)
            `ACC_MODE_CFG_OFS: begin
               modeCfg_ff <= {27'h0, hwdata[4:0]};
            end
            `ACC_PERIOD_OFS: begin
               period_ff <= hwdata[23:0];
            end
            `ACC_LATENCY_OFS: begin
               latency_ff <= hwdata[3:0];
            end
            default: begin
               modeCfg_ff <= modeCfg_ff;
            end
         endcase
      end
   end

   // Reset flag is set by any reset and wins over a clear.
   always_ff @(posedge clk) begin
      if (regRst) begin
         rstFlag_ff <= 1'b1;
      end else if (clkEn && flagClr) begin
         rstFlag_ff <= 1'b0;
      end
   end

   // Read data is registered in the address phase, zero wait states.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else if (clkEn) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         if (busAct && !hwrite) begin
            case (haddr[7:0])
               `ACC_MODE_CFG_OFS: hrdata <= modeCfg_ff;
               `ACC_PERIOD_OFS:   hrdata <= {8'h00, period_ff};
               `ACC_LATENCY_OFS:  hrdata <= {28'h0, latency_ff};
               `ACC_STATUS_OFS: begin
                  hrdata <= {28'h0, commRdy_ff,
                             (state_ff == acc_pkg::ST_DELAY) ||
                             (state_ff == acc_pkg::ST_CONV),
                             extClkSel, rstFlag_ff};
               end
               default: hrdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // ****************************************************************
   // Conversion sequencer.
   // ****************************************************************
   logic [23:0] cnt_ff;       // Cycle counter of the current phase.
   logic [3:0]  dlyLeft_ff;   // Delay units still to wait.
   logic [3:0]  latLeft_ff;   // Settling periods still to discard.
   logic        stopPend_ff;  // Stop asked in continuous mode.
   logic        startReq;     // Start edge or start command.
   logic        cntDone;      // Current phase count expired.
   logic        periodEnd;    // Conversion period expired.

   assign startReq  = startRise | cmdIn.start;
   assign periodEnd = (state_ff == acc_pkg::ST_CONV) &&
                      (cnt_ff == period_ff - 24'h1);

   // Next-state logic.
   always_comb begin
      nxt_state = state_ff;
      cntDone   = 1'b0;
      case (state_ff)
         acc_pkg::ST_POR: begin
            cntDone = (cnt_ff == POR_C);
            if (cntDone) nxt_state = acc_pkg::ST_BOOT;
         end
         acc_pkg::ST_BOOT: begin
            cntDone = (cnt_ff == BOOT_C);
            if (cntDone) begin
               nxt_state = pinsSync.start ? acc_pkg::ST_DELAY
                                          : acc_pkg::ST_IDLE;
            end
         end
         acc_pkg::ST_IDLE: begin
            if (startReq) nxt_state = acc_pkg::ST_DELAY;
         end
         acc_pkg::ST_DELAY: begin
            cntDone = (cnt_ff == DLY_UNIT_C - 24'h1);
            if (startReq) begin
               nxt_state = acc_pkg::ST_DELAY;
            end else if (dlyLeft_ff == 4'h0 ||
                         (cntDone && dlyLeft_ff == 4'h1)) begin
               nxt_state = acc_pkg::ST_CONV;
            end
         end
         acc_pkg::ST_CONV: begin
            if (startReq) begin
               nxt_state = acc_pkg::ST_DELAY;
            end else if (periodEnd && latLeft_ff == 4'h0 &&
                         (convMode || stopPend_ff)) begin
               nxt_state = acc_pkg::ST_IDLE;
            end
         end
         default: nxt_state = acc_pkg::ST_IDLE;
      endcase
   end

   // State register; soft resets skip the power-up wait.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         state_ff <= acc_pkg::ST_POR;
      end else if (softRst) begin
         state_ff <= acc_pkg::ST_BOOT;
      end else if (clkEn) begin
         state_ff <= nxt_state;
      end
   end

   // Phase counters restart on every state change or restart.
   always_ff @(posedge clk) begin
      if (regRst) begin
         cnt_ff     <= 24'h0;
         dlyLeft_ff <= 4'h0;
         latLeft_ff <= 4'h0;
      end else if (clkEn) begin
         if (startReq && state_ff != acc_pkg::ST_POR &&
             state_ff != acc_pkg::ST_BOOT) begin
            cnt_ff     <= 24'h0;
            dlyLeft_ff <= delayField;
            latLeft_ff <= latency_ff;
         end else if (nxt_state != state_ff) begin
            cnt_ff     <= 24'h0;
            dlyLeft_ff <= delayField;
            latLeft_ff <= latency_ff;
         end else if (state_ff == acc_pkg::ST_DELAY && cntDone) begin
            cnt_ff     <= 24'h0;
            dlyLeft_ff <= dlyLeft_ff - 4'h1;
         end else if (periodEnd) begin
            cnt_ff <= 24'h0;
            if (latLeft_ff != 4'h0) begin
               latLeft_ff <= latLeft_ff - 4'h1;
            end
         end else begin
            cnt_ff <= cnt_ff + 24'h1;
         end
      end
   end

   // A stop only marks the run; pulse mode never looks at it.
   always_ff @(posedge clk) begin
      if (regRst) begin
         stopPend_ff <= 1'b0;
      end else if (clkEn) begin
         if (startReq) begin
            stopPend_ff <= 1'b0;
         end else if (startFall || cmdIn.stop) begin
            stopPend_ff <= 1'b1;
         end
      end
   end

   // ****************************************************************
   // Outputs.
   // ****************************************************************
   // Ready is low through power-up, high while converting, low at each
   // settled result; the filter runs only after the start delay.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         resultReadyN <= 1'b0;
         filterRun    <= 1'b0;
         commRdy_ff   <= 1'b0;
      end else if (softRst) begin
         resultReadyN <= 1'b1;
         filterRun    <= 1'b0;
         commRdy_ff   <= 1'b1;
      end else if (clkEn) begin
         filterRun <= (nxt_state == acc_pkg::ST_CONV);
         if (state_ff == acc_pkg::ST_POR && cntDone) begin
            resultReadyN <= 1'b1;
            commRdy_ff   <= 1'b1;
         end else if (nxt_state == acc_pkg::ST_DELAY &&
                      (state_ff != acc_pkg::ST_DELAY || startReq)) begin
            resultReadyN <= 1'b1;
         end else if (periodEnd && latLeft_ff == 4'h0) begin
            resultReadyN <= 1'b0;
         end else if (periodEnd) begin
            resultReadyN <= 1'b1;
         end else if (state_ff == acc_pkg::ST_CONV && cnt_ff == 24'h0 &&
                      !resultReadyN) begin
            resultReadyN <= 1'b1;
         end
      end
   end

endmodule : acc_conv_ctl

// ===== dv/acc_conv_ctl_asserts.sv
// Port checker for the conversion control block.
`timescale 1ns/1ns
module acc_conv_ctl_asserts #(
   parameter int POR_CYCLES = 64
) (
   input wire logic               clk,
   input wire logic               resetn,
   input wire logic               hreadyout,
   input wire logic               hresp,
   input wire acc_pkg::acc_pins_t pinsIn,
   input wire acc_pkg::acc_cmd_t  cmdIn,
   input wire logic               resultReadyN,
   input wire logic               filterRun,
   input wire logic               extClkSel
);
   // ********
   // Helper counters.
   // ********
   logic [19:0] porCnt_ff;   // Cycles since power-up reset.
   logic [19:0] sinceRst_ff; // Cycles since any reset.
   logic [7:0]  quiet_ff;    // Cycles the clock pin stood still.
   logic        lastExt_ff;  // Previous clock pin level.
   // Counts saturate so that long runs never wrap.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         porCnt_ff <= 20'h00000;
      end else if (porCnt_ff != 20'hfffff) begin
         porCnt_ff <= porCnt_ff + 20'h00001;
      end
   end
   // Any of the three reset sources restarts this count.
   always_ff @(posedge clk) begin
      if (!resetn || !pinsIn.resetN || cmdIn.reset) begin
         sinceRst_ff <= 20'h00000;
      end else if (sinceRst_ff != 20'hfffff) begin
         sinceRst_ff <= sinceRst_ff + 20'h00001;
      end
   end
   // Measures how long the clock pin has not moved.
   always_ff @(posedge clk) begin
      lastExt_ff <= pinsIn.extClk;
      if (!resetn || pinsIn.extClk != lastExt_ff) begin
         quiet_ff <= 8'h00;
      end else if (quiet_ff != 8'hff) begin
         quiet_ff <= quiet_ff + 8'h01;
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   chk_reset_quiet: assert property (
      !resetn |=> !resultReadyN && !filterRun && !extClkSel)
      else $error("outputs not cleared in reset");
   chk_por_low: assert property (disable iff (!resetn)
      porCnt_ff < 20'(POR_CYCLES - 2) |-> !resultReadyN)
      else $error("ready rose during power-up wait");
   chk_por_high: assert property (disable iff (!resetn)
      porCnt_ff == 20'(POR_CYCLES + 8) |-> resultReadyN)
      else $error("ready not high after power-up wait");
   chk_boot_idle: assert property (disable iff (!resetn)
      sinceRst_ff < 20'd512 |-> !filterRun)
      else $error("conversion ran during boot wait");
   chk_start_high: assert property (disable iff (!resetn)
      cmdIn.start && sinceRst_ff > 20'(POR_CYCLES + 520) |=> resultReadyN)
      else $error("ready not high after start");
   chk_fall_run: assert property (disable iff (!resetn)
      $fell(resultReadyN) |-> $past(filterRun))
      else $error("result flagged without a conversion");
   chk_ext_seen: assert property (disable iff (!resetn)
      $changed(pinsIn.extClk) |-> ##[1:6] extClkSel)
      else $error("clock edge not detected");
   chk_ext_lost: assert property (disable iff (!resetn)
      quiet_ff > 8'd40 |-> !extClkSel)
      else $error("still on clock pin after it stopped");
   chk_cmd_reset: assert property (disable iff (!resetn)
      cmdIn.reset |=> !filterRun [*8])
      else $error("conversion ran after reset command");
   chk_bus_okay: assert property (disable iff (!resetn)
      hreadyout && !hresp)
      else $error("bus wait or error response");
   cov_start: cover property (disable iff (!resetn) cmdIn.start);
   cov_result: cover property (disable iff (!resetn) $fell(resultReadyN));
   cov_ext: cover property (disable iff (!resetn) $rose(extClkSel));
endmodule : acc_conv_ctl_asserts

bind acc_conv_ctl acc_conv_ctl_asserts #(.POR_CYCLES(POR_CYCLES)) i_chk (
   .clk(clk), .resetn(resetn), .hreadyout(hreadyout), .hresp(hresp),
   .pinsIn(pinsIn), .cmdIn(cmdIn), .resultReadyN(resultReadyN),
   .filterRun(filterRun), .extClkSel(extClkSel));

// ===== dv/acc_host_model.sv
// Host model driving the start, reset and clock pins and the commands.
`timescale 1ns/1ns
module acc_host_model (
   input  wire logic          clk,
   input  wire logic          extOn,
   output acc_pkg::acc_pins_t pins,
   output acc_pkg::acc_cmd_t  cmd
);
   logic ext;   // External clock pin level.
   logic rstN;  // Reset pin, active low.
   logic start; // Start pin level.
   logic chipSelectN; // Serial chip select, active low.
   assign pins = {ext, rstN, start};
   // Pins idle with reset released and the clock pin grounded.
   initial begin
      ext = 1'b0;
      rstN = 1'b1;
      start = 1'b0;
      chipSelectN = 1'b0;
      cmd = 3'b000;
   end
   // Clock pin toggles off the bench clock phase, grounded when off.
   initial begin
      #3;
      forever #80 ext = extOn ? ~ext : 1'b0;
   end
   // A command is a one-cycle pulse; the start pin is left as it is.
   task automatic sendCmd(input logic [2:0] c);
      if (c[0]) begin
         @(posedge clk);
         chipSelectN <= 1'b1;
         @(posedge clk);
         chipSelectN <= 1'b0;
      end
      @(posedge clk);
      cmd <= c;
      @(posedge clk);
      cmd <= 3'b000;
   endtask : sendCmd
   // Sets the start pin level.
   task automatic setStart(input logic v);
      @(posedge clk);
      start <= v;
   endtask : setStart
   // Holds the reset pin low for n cycles, at least four.
   task automatic pulseReset(input int n);
      @(posedge clk);
      rstN <= 1'b0;
      repeat (n) @(posedge clk);
      rstN <= 1'b1;
   endtask : pulseReset
endmodule : acc_host_model

// ===== dv/tb.sv
// Self-checking testbench of the conversion control block.
`timescale 1ns/1ns
`include "acc_params.svh"
module tb;
   localparam int POR = 64;
   localparam logic [31:0] MODE = 32'(`ACC_MODE_CFG_OFS);
   localparam logic [31:0] PER  = 32'(`ACC_PERIOD_OFS);
   localparam logic [31:0] STAT = 32'(`ACC_STATUS_OFS);
   typedef struct packed {
      logic        wr;
      logic [31:0] addr, data, mask, exp;
   } acc_row_t;
   // ********
   // Stimulus rows: write or read, address, data, mask, expected.
   // ********
   acc_row_t rows [12] = '{
      '{1'b0, MODE, 32'h0, 32'h1f, 32'h01},
      '{1'b0, PER, 32'h0, 32'hffffff, 32'h4e20},
      '{1'b0, 32'h08, 32'h0, 32'hf, 32'h0},
      '{1'b0, STAT, 32'h0, 32'h9, 32'h9},
      '{1'b1, 32'h40, 32'hffffffff, 32'h0, 32'h0},
      '{1'b0, 32'h40, 32'h0, 32'hffffffff, 32'h0},
      '{1'b1, STAT, 32'h1, 32'h0, 32'h0},
      '{1'b0, STAT, 32'h0, 32'h1, 32'h0},
      '{1'b1, PER, 32'h28, 32'h0, 32'h0},
      '{1'b0, PER, 32'h0, 32'hffffff, 32'h28},
      '{1'b1, MODE, 32'h10, 32'h0, 32'h0},
      '{1'b0, MODE, 32'h0, 32'h1f, 32'h10}};
   logic        clk, resetn, clkEn, extOn, hsel, hwrite;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic        hreadyout, hresp, resultReadyN, filterRun, extClkSel;
   acc_pkg::acc_pins_t pins;
   acc_pkg::acc_cmd_t  cmd;
   int          miscompares, samples_checked, cnt;
   acc_conv_ctl #(.POR_CYCLES(POR)) i_dut (
      .clk(clk), .resetn(resetn), .clkEn(clkEn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .pinsIn(pins), .cmdIn(cmd),
      .resultReadyN(resultReadyN), .filterRun(filterRun),
      .extClkSel(extClkSel));
   acc_host_model i_host (.clk(clk), .extOn(extOn), .pins(pins), .cmd(cmd));
   // Compares one value and counts it.
   task automatic check(input logic [31:0] seen, exp, input string what);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %0t %s: %h not %h", $time, what, seen, exp);
      end
   endtask : check
   // Prints the counts and the verdict, then stops.
   task automatic end_sim();
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : end_sim
   // Waits for hready at a rising edge, bounded.
   task automatic busWait();
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      if (n >= 20) begin
         miscompares++;
         end_sim();
      end
   endtask : busWait
   // One single word transfer: address phase, then data phase.
   task automatic busXfer(input logic wr, input logic [31:0] a, d,
                          output logic [31:0] r);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= wr;
      htrans <= 2'b10;
      busWait();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      busWait();
      r = hrdata;
   endtask : busXfer
   // Counts edges until the ready output shows a level; n = lim on time out.
   task automatic waitRdy(input logic lvl, input int lim, output int n);
      n = 0;
      while (resultReadyN !== lvl && n < lim) begin
         @(posedge clk);
         n++;
      end
      if (resultReadyN !== lvl) begin
         miscompares++;
         end_sim();
      end
   endtask : waitRdy
   // Counts edges with the ready output high over a span.
   task automatic countHigh(input int lim, output int n);
      n = 0;
      repeat (lim) begin
         @(posedge clk);
         if (resultReadyN !== 1'b0) n++;
      end
   endtask : countHigh
   // Free-running bench clock.
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // Run is cut short if anything hangs.
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      end_sim();
   end
   // Main sequence.
   initial begin
      {resetn, extOn, hsel, hwrite, htrans, haddr, hwdata} = '0;
      clkEn = 1'b1;
      hsize = 3'b010;
      miscompares = 0;
      samples_checked = 0;
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      waitRdy(1'b1, 200, cnt);
      check(32'(cnt >= POR - 2 && cnt <= POR + 4), 1, "por");
      foreach (rows[i]) begin
         busXfer(rows[i].wr, rows[i].addr, rows[i].data, rd);
         if (!rows[i].wr) check(rd & rows[i].mask, rows[i].exp, "reg");
      end
      hsize <= 3'b000;
      busXfer(1'b1, MODE, 32'h0f, rd);
      hsize <= 3'b010;
      busXfer(1'b0, MODE, 32'h0, rd);
      check(rd, 32'h10, "byte write");
      busXfer(1'b1, MODE, 32'h0, rd);
      $display("done: registers");
      repeat (600) @(posedge clk);
      i_host.sendCmd(3'b100);
      waitRdy(1'b1, 5, cnt);
      check(32'(cnt <= 2), 1, "rise");
      waitRdy(1'b0, 100, cnt);
      check(32'(cnt >= 38 && cnt <= 44), 1, "first");
      waitRdy(1'b1, 5, cnt);
      waitRdy(1'b0, 100, cnt);
      check(32'(cnt >= 37 && cnt <= 44), 1, "next");
      waitRdy(1'b1, 5, cnt);
      repeat (10) @(posedge clk);
      i_host.sendCmd(3'b010);
      waitRdy(1'b0, 100, cnt);
      check(32'(cnt >= 22 && cnt <= 34), 1, "finish");
      countHigh(100, cnt);
      check(cnt, 0, "halted");
      i_host.sendCmd(3'b100);
      waitRdy(1'b1, 5, cnt);
      repeat (20) @(posedge clk);
      i_host.sendCmd(3'b100);
      waitRdy(1'b0, 100, cnt);
      check(32'(cnt >= 37 && cnt <= 44), 1, "restart");
      i_host.sendCmd(3'b010);
      repeat (100) @(posedge clk);
      check(resultReadyN, 0, "stopped");
      $display("done: continuous");
      busXfer(1'b1, MODE, 32'h10, rd);
      i_host.setStart(1'b1);
      waitRdy(1'b1, 10, cnt);
      repeat (10) @(posedge clk);
      i_host.setStart(1'b0);
      i_host.sendCmd(3'b010);
      waitRdy(1'b0, 100, cnt);
      check(32'(cnt >= 20 && cnt <= 34), 1, "pulse");
      countHigh(100, cnt);
      check(cnt, 0, "one shot");
      i_host.sendCmd(3'b100);
      clkEn <= 1'b0;
      repeat (30) @(posedge clk);
      clkEn <= 1'b1;
      waitRdy(1'b0, 100, cnt);
      check(32'(cnt >= 39 && cnt <= 45), 1, "freeze");
      busXfer(1'b1, 32'(`ACC_LATENCY_OFS), 32'h2, rd);
      i_host.sendCmd(3'b100);
      waitRdy(1'b1, 5, cnt);
      waitRdy(1'b0, 200, cnt);
      check(32'(cnt >= 117 && cnt <= 124), 1, "latency");
      $display("done: pulse");
      @(posedge clk);
      extOn <= 1'b1;
      repeat (30) @(posedge clk);
      check(extClkSel, 1, "ext on");
      busXfer(1'b0, STAT, 32'h0, rd);
      check(rd[1], 1, "clock bit");
      extOn <= 1'b0;
      repeat (60) @(posedge clk);
      check(extClkSel, 0, "ext off");
      $display("done: clock");
      i_host.sendCmd(3'b001);
      busXfer(1'b0, STAT, 32'h0, rd);
      check(rd[0], 1, "flag");
      busXfer(1'b0, MODE, 32'h0, rd);
      check(rd, 32'h1, "defaults");
      i_host.setStart(1'b1);
      i_host.pulseReset(4);
      cnt = 0;
      while (filterRun !== 1'b1 && cnt < 4000) begin
         @(posedge clk);
         cnt++;
      end
      if (filterRun !== 1'b1) begin
         miscompares++;
         end_sim();
      end
      check(32'(cnt >= 3008 && cnt <= 3025), 1, "boot");
      i_host.setStart(1'b0);
      $display("done: resets");
      end_sim();
   end
endmodule : tb
